// ---- pkg/sbha_map.vh ----
// sbha_map.vh: address map, field positions and counts of the host access
// block. assumes 16-bit host i/o addresses and an 8-bit host data bus.
`ifndef SBHA_MAP_VH
`define SBHA_MAP_VH

// host i/o ports
`define SBHA_SER_BASE      16'hfc30
`define SBHA_SER_LAST      16'hfc3f
`define SBHA_BOARD_SEL     16'hfc40
`define SBHA_CTRL_LATCH    16'hfc41

// control latch fields
`define SBHA_CTL_RUN       3
`define SBHA_CTL_DMA       2
`define SBHA_CTL_PAGE_HI   1
`define SBHA_CTL_PAGE_LO   0

// output bit positions
`define SBHA_OP_LCPU_IRQ   7
`define SBHA_OP_HOST_IRQ   6
`define SBHA_OP_LPAGE_HI   5
`define SBHA_OP_LPAGE_LO   4
`define SBHA_OP_DPAGE_HI   3
`define SBHA_OP_DPAGE_LO   2
`define SBHA_OP_RTS_B      1
`define SBHA_OP_RTS_A      0

// serial register index of the output bits and of the input bits (set/reset style kept simple)
`define SBHA_SER_OPR_IDX   4'hd
`define SBHA_SER_IP_IDX    4'hd

// reset values
`define SBHA_OPR_RESET     8'h00
`define SBHA_CTL_RESET     4'h0

// timing counts in 8 mhz clocks, burst limit in host accesses
`define SBHA_ACCESS_CYCLES 3'h3
`define SBHA_HOLD_SHORT    4'h4
`define SBHA_HOLD_LONG     4'h8
`define SBHA_BURST_LIMIT   4'h8

`endif

// ---- hdl/sbha_sync2.v ----
// sbha_sync2.v: two-flop synchroniser for a bus of levels.
// assumes the input is a level held longer than two clocks.
`timescale 1ns/1ps
module sbha_sync2 #(
	parameter         W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst_b,
	// levels
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] stage1_r;
	reg [W-1:0] stage2_r;

	// first stage feeds only the second; reset to idle level, no false edge
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage1_r <= INIT;
			stage2_r <= INIT;
		end else begin
			stage1_r <= din;
			stage2_r <= stage1_r;
		end
	end
	assign dout = stage2_r;
endmodule // sbha_sync2

// ---- hdl/sbha_host_access.v ----
// sbha_host_access.v: host access, board select and page logic of a slave
// processor board. assumes host strobes and status arrive from the bus
// unsynchronised, local cpu grant and halt from another device.
`timescale 1ns/1ps
`include "sbha_map.vh"
module sbha_host_access (
	// clock and reset
	input  wire        clock,
	input  wire        rst_b,
	// straps
	input  wire [7:0]  windowSwitch,
	input  wire [3:0]  boardSwitch,
	input  wire        holdLong,
	input  wire        mem256k,
	// host bus
	input  wire [23:0] hostAddr,
	input  wire [7:0]  hostDataOut,
	output reg  [7:0]  hostDataIn,
	input  wire        statMemRead,
	input  wire        statWriteOut_b,
	input  wire        statOut,
	input  wire        statIn,
	input  wire        hostReadStrobe,
	input  wire        hostWrite_b,
	input  wire        holdAck,
	output wire        hostReady,
	output wire        hostIrq_b,
	// local cpu side
	output wire        localBusRequest_b,
	input  wire        localBusGrant_b,
	input  wire        localHalt_b,
	output wire        localCpuReset_b,
	output wire        localCpuIrq_b,
	input  wire        serialCtrlIrq_b,
	// internal bus strobes
	output reg         memRequest_b,
	output reg         ioRequest_b,
	output reg         intRead_b,
	output reg         intWrite_b,
	output reg  [3:0]  internalAddrLow,
	output wire        windowMatch_b,
	output wire [1:0]  dramPage,
	// serial register file link
	output wire        serialCtrlReset_b,
	input  wire [7:0]  serialRdData,
	// modem lines
	input  wire        clearToSendChanA,
	input  wire        clearToSendChanB,
	output wire        requestToSendChanA,
	output wire        requestToSendChanB,
	// register views
	output wire [7:0]  outputBitsReg,
	output wire [6:0]  inputBits
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_REQ   = 3'h1;
	localparam ST_SYNC  = 3'h2;
	localparam ST_XFER  = 3'h3;
	localparam ST_DONE  = 3'h4;
	localparam ST_YIELD = 3'h5;

	// synchronised bus inputs
	wire [31:0] hostAddrS;
	wire [7:0]  hostDataS;
	wire [8:0]  ctlS;
	sbha_sync2 #(.W(32)) uSyncA (
		.clock (clock),
		.rst_b (rst_b),
		.din   ({hostAddr, hostDataOut}),
		.dout  ({hostAddrS[23:0], hostDataS})
	);
	assign hostAddrS[31:24] = 8'h00;
	// reset to the idle level of each line: write strobe, write status, grant and halt high, the rest low
	sbha_sync2 #(.W(9), .INIT(9'h08b)) uSyncC (
		.clock (clock),
		.rst_b (rst_b),
		.din   ({statMemRead, statWriteOut_b, statOut, statIn,
			hostReadStrobe, hostWrite_b, holdAck, localBusGrant_b,
			localHalt_b}),
		.dout  (ctlS)
	);
	wire sMemR   = ctlS[8];
	wire sWo_b   = ctlS[7];
	wire sOut    = ctlS[6];
	wire sInp    = ctlS[5];
	wire rdStb   = ctlS[4];
	wire wrStb_b = ctlS[3];
	wire hldAck  = ctlS[2];
	wire grant_b = ctlS[1];
	wire halt_b  = ctlS[0];

	// address compare helper, used for the board select and control latch decodes
	function portHit;
		input [15:0] a;
		input [15:0] p;
		begin
			portHit = (a == p);
		end
	endfunction

	// state
	reg        boardSel_r;
	reg [3:0]  ctl_r;
	reg [7:0]  opr_r;
	reg [1:0]  seenPage_r;
	reg        wrPrev_r;
	reg [2:0]  st_r;
	reg [2:0]  cnt_r;
	reg [3:0]  hold_r;
	reg [3:0]  burst_r;
	reg        isIo_r;
	reg        isWr_r;
	reg        doneWait_r;

	wire [15:0] ioA = hostAddrS[15:0];
	wire wrTrail = !wrPrev_r && wrStb_b; // write strobe rising, trailing edge
	wire ioWr = sOut;

	// board valid and window match
	wire dmaDesig = ctl_r[`SBHA_CTL_DMA];
	wire boardValid = hldAck ? dmaDesig : boardSel_r;
	wire winHit = boardValid &&
		(hostAddrS[23:16] == windowSwitch);
	assign windowMatch_b = !winHit;

	// requests that use the internal bus
	wire memReq = winHit && (sMemR || !sWo_b) && !sOut && !sInp &&
		(rdStb || !wrStb_b);
	wire serHit = (ioA >= `SBHA_SER_BASE) && (ioA <= `SBHA_SER_LAST);
	wire ioReq = boardValid && serHit && (sInp || sOut) &&
		(rdStb || !wrStb_b);
	wire anyReq = memReq || ioReq;

	// write-only ports, no internal bus
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wrPrev_r   <= 1'b1;
			boardSel_r <= 1'b0;
			ctl_r      <= `SBHA_CTL_RESET;
		end else begin
			wrPrev_r <= wrStb_b;
			if (wrTrail && ioWr && portHit(ioA, `SBHA_BOARD_SEL))
				boardSel_r <= (hostDataS[3:0] == boardSwitch);
			if (wrTrail && ioWr && boardSel_r &&
				portHit(ioA, `SBHA_CTRL_LATCH))
				ctl_r <= hostDataS[3:0];
		end
	end

	// local cpu and serial reset follow latch bit 3
	assign localCpuReset_b   = ctl_r[`SBHA_CTL_RUN];
	assign serialCtrlReset_b = ctl_r[`SBHA_CTL_RUN];

	// access sequencer: wait, request, count, strobe, release
	wire holdLen = holdLong;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_r       <= ST_IDLE;
			cnt_r      <= 3'h0;
			hold_r     <= 4'h0;
			burst_r    <= 4'h0;
			isIo_r     <= 1'b0;
			isWr_r     <= 1'b0;
			doneWait_r <= 1'b0;
		end else begin
			case (st_r)
			ST_IDLE: begin
				// hold-off counts clocks while the grant is still kept
				if (hold_r != 4'h0)
					hold_r <= hold_r - 4'h1;
				if (doneWait_r) begin
					if (!anyReq)
						doneWait_r <= 1'b0;
				end else if (anyReq) begin
					isIo_r <= ioReq;
					isWr_r <= !wrStb_b;
					if (burst_r == `SBHA_BURST_LIMIT)
						st_r <= ST_YIELD;
					else
						st_r <= ST_REQ;
				end
			end
			ST_REQ: begin
				if (!grant_b) begin
					cnt_r <= 3'h0;
					st_r  <= ST_SYNC;
				end
			end
			ST_SYNC: st_r <= ST_XFER; // delayed grant
			ST_XFER: begin
				if (cnt_r == `SBHA_ACCESS_CYCLES) begin
					st_r <= ST_DONE;
				end else begin
					cnt_r <= cnt_r + 3'h1;
				end
			end
			ST_DONE: begin
				doneWait_r <= 1'b1;
				burst_r    <= burst_r + 4'h1;
				hold_r     <= holdLen ? `SBHA_HOLD_LONG
					: `SBHA_HOLD_SHORT;
				st_r       <= ST_IDLE;
			end
			ST_YIELD: begin
				// drop request until the cpu takes its bus back
				hold_r <= 4'h0;
				if (grant_b) begin
					burst_r <= 4'h0;
					st_r    <= ST_REQ;
				end
			end
			default: st_r <= ST_IDLE;
			endcase
			if (st_r == ST_IDLE && hold_r == 4'h0 && !anyReq)
				burst_r <= 4'h0;
		end
	end

	assign localBusRequest_b = !((st_r == ST_REQ) || (st_r == ST_SYNC) ||
		(st_r == ST_XFER) || (st_r == ST_DONE) || (hold_r != 4'h0));
	assign hostReady = !(anyReq && !doneWait_r) || (st_r == ST_DONE);

	// internal strobes after delayed grant
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			memRequest_b    <= 1'b1;
			ioRequest_b     <= 1'b1;
			intRead_b       <= 1'b1;
			intWrite_b      <= 1'b1;
			internalAddrLow <= 4'h0;
		end else begin
			memRequest_b    <= !((st_r == ST_XFER) && !isIo_r);
			ioRequest_b     <= !((st_r == ST_XFER) && isIo_r);
			intRead_b       <= !((st_r == ST_XFER) && !isWr_r);
			intWrite_b      <= !((st_r == ST_XFER) && isWr_r);
			internalAddrLow <= ioA[3:0];
		end
	end

	// output bits, written through serial register index
	wire serWr = (st_r == ST_DONE) && isIo_r && isWr_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			opr_r <= `SBHA_OPR_RESET;
		end else if (!ctl_r[`SBHA_CTL_RUN]) begin
			opr_r <= `SBHA_OPR_RESET;
		end else if (serWr && internalAddrLow == `SBHA_SER_OPR_IDX) begin
			opr_r <= hostDataS;
		end
	end
	assign outputBitsReg      = opr_r;
	assign hostIrq_b          = opr_r[`SBHA_OP_HOST_IRQ];
	assign requestToSendChanB = opr_r[`SBHA_OP_RTS_B];
	assign requestToSendChanA = opr_r[`SBHA_OP_RTS_A];
	assign localCpuIrq_b = opr_r[`SBHA_OP_LCPU_IRQ] &
		serialCtrlIrq_b;

	// page mux for the dram upper bits
	wire [1:0] localPage = opr_r[`SBHA_OP_LPAGE_HI:`SBHA_OP_LPAGE_LO];
	wire [1:0] dmaPage   = opr_r[`SBHA_OP_DPAGE_HI:`SBHA_OP_DPAGE_LO];
	wire [1:0] hostPage  = ctl_r[`SBHA_CTL_PAGE_HI:`SBHA_CTL_PAGE_LO];
	wire [1:0] pageSel = grant_b ? localPage :
		(hldAck ? dmaPage : hostPage);
	assign dramPage = mem256k ? pageSel : 2'h0;

	// page last seen by host or dma
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			seenPage_r <= 2'h0;
		else if (!grant_b)
			seenPage_r <= hldAck ? dmaPage : hostPage;
	end

	// modem inputs pass the synchroniser too
	wire [2:0] ctsS;
	sbha_sync2 #(.W(3)) uSyncM (
		.clock (clock),
		.rst_b (rst_b),
		.din   ({clearToSendChanB, clearToSendChanA, 1'b0}),
		.dout  (ctsS)
	);
	assign inputBits = {halt_b, seenPage_r, 2'h0, ctsS[2:1]};

	// read data returned to host
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			hostDataIn <= 8'h00;
		else if ((st_r == ST_XFER) && isIo_r && !isWr_r)
			hostDataIn <= (internalAddrLow == `SBHA_SER_IP_IDX) ?
				{1'b0, inputBits} : serialRdData;
	end

endmodule // sbha_host_access

// ---- tb/sbha_host_access_props.sv ----
// sbha_host_access_props.sv: port checker for the host access block.
// assumes it sees only the block's top ports, one clock domain.
`timescale 1ns/1ps
module sbha_host_access_props (
	// clock and reset
	input logic        clock,
	input logic        rst_b,
	// watched ports
	input logic [7:0]  windowSwitch,
	input logic        mem256k,
	input logic [23:0] hostAddr,
	input logic        hostReady,
	input logic        hostIrq_b,
	input logic        localBusRequest_b,
	input logic        localBusGrant_b,
	input logic        localCpuReset_b,
	input logic        localCpuIrq_b,
	input logic        serialCtrlIrq_b,
	input logic        memRequest_b,
	input logic        ioRequest_b,
	input logic        intRead_b,
	input logic        windowMatch_b,
	input logic [1:0]  dramPage,
	input logic        serialCtrlReset_b,
	input logic        requestToSendChanA,
	input logic        requestToSendChanB,
	input logic [7:0]  outputBitsReg
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// output bit wiring and resets
	a_irq_wired_or: assert property (
		localCpuIrq_b == (outputBitsReg[7] & serialCtrlIrq_b))
		else $error("cpu irq");
	a_out_bit_map: assert property (
		{hostIrq_b, requestToSendChanB, requestToSendChanA} ==
		{outputBitsReg[6], outputBitsReg[1:0]}) else $error("output bits");
	a_serial_reset_tie: assert property (
		serialCtrlReset_b == localCpuReset_b) else $error("serial reset");
	// access sequencing
	a_strobe_needs_grant: assert property (
		!memRequest_b || !ioRequest_b |-> !localBusGrant_b)
		else $error("strobe no grant");
	a_request_held: assert property (
		!ioRequest_b |-> !localBusRequest_b) else $error("request dropped");
	a_read_strobe_len: assert property (
		$fell(intRead_b) |-> (!intRead_b)[*4]) else $error("strobe length");
	a_wait_ends: assert property (
		$fell(memRequest_b) |-> ##[3:8] hostReady)
		else $error("wait not ended");
	// window and page choice
	a_no_window: assert property (
		(hostAddr[23:16] != windowSwitch)[*4] |-> windowMatch_b)
		else $error("window match");
	a_local_page: assert property (
		(mem256k && localBusGrant_b)[*4] |-> dramPage == outputBitsReg[5:4])
		else $error("local page");
	// main scenarios reached
	c_mem_strobe: cover property ($fell(memRequest_b));
	c_io_strobe: cover property ($fell(ioRequest_b));
	c_wait_end: cover property ($rose(hostReady));
endmodule // sbha_host_access_props

bind sbha_host_access sbha_host_access_props sbha_host_access_props_inst (
	.clock(clock), .rst_b(rst_b), .windowSwitch(windowSwitch),
	.mem256k(mem256k), .hostAddr(hostAddr), .hostReady(hostReady),
	.hostIrq_b(hostIrq_b), .localBusRequest_b(localBusRequest_b),
	.localBusGrant_b(localBusGrant_b), .localCpuReset_b(localCpuReset_b),
	.localCpuIrq_b(localCpuIrq_b), .serialCtrlIrq_b(serialCtrlIrq_b),
	.memRequest_b(memRequest_b), .ioRequest_b(ioRequest_b),
	.intRead_b(intRead_b), .windowMatch_b(windowMatch_b),
	.dramPage(dramPage), .serialCtrlReset_b(serialCtrlReset_b),
	.requestToSendChanA(requestToSendChanA),
	.requestToSendChanB(requestToSendChanB), .outputBitsReg(outputBitsReg));

// ---- tb/sbha_host_model.sv ----
// sbha_host_model.sv: bus host model running memory and port cycles.
// assumes the block holds a cycle by keeping hostReady low.
`timescale 1ns/1ps
module sbha_host_model (
	// clock
	input logic         clock,
	// host bus
	output logic [23:0] hostAddr,
	output logic [7:0]  hostDataOut,
	output logic        statMemRead,
	output logic        statWriteOut_b,
	output logic        statOut,
	output logic        statIn,
	output logic        hostReadStrobe,
	output logic        hostWrite_b,
	output logic        holdAck,
	input logic         hostReady,
	input logic [7:0]  hostDataIn
);
	// idle bus from time zero
	initial begin
		{hostAddr, hostDataOut} = '1;
		{statMemRead, statOut, statIn, hostReadStrobe, holdAck} = '0;
		{statWriteOut_b, hostWrite_b} = 2'h3;
	end
	// one cycle, held whole until ready is seen high
	task automatic run(input bit io, wr, dma, input logic [23:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clock);
		holdAck <= dma;
		hostAddr <= a;
		hostDataOut <= wr ? d : ~d;
		statMemRead <= !io && !wr;
		statWriteOut_b <= !wr;
		statOut <= io && wr;
		statIn <= io && !wr;
		hostReadStrobe <= !wr;
		hostWrite_b <= !wr;
		repeat (4) @(posedge clock);
		// a hang here is caught by the bench's cycle ceiling
		while (hostReady !== 1'b1)
			@(posedge clock);
		q = hostDataIn;
		// strobes end first, status and address outlive them by a clock
		hostReadStrobe <= 1'b0;
		hostWrite_b <= 1'b1;
		@(posedge clock);
		{statMemRead, statOut, statIn, holdAck} <= '0;
		statWriteOut_b <= 1'b1;
		hostAddr <= ~a; // released lines show no stale value
		hostDataOut <= ~d;
		repeat (5) @(posedge clock);
	endtask
endmodule // sbha_host_model

// ---- tb/sbha_host_access_tb_top.sv ----
// sbha_host_access_tb_top.sv: self-checking bench of the host access block.
// assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module sbha_host_access_tb_top;
	logic clock, rst_b, localBusGrant_b, serialCtrlIrq_b;
	logic clearToSendChanA, memRequest_b, ioRequest_b, intRead_b, intWrite_b;
	logic [7:0] serialRdData, hostDataIn, outputBitsReg, q;
	logic [6:0] inputBits;
	logic [23:0] hostAddr;
	logic [7:0] hostDataOut, seenMatch;
	logic [3:0] internalAddrLow, seenAddr;
	logic [1:0] dramPage, seenPage;
	logic statMemRead, statWriteOut_b, statOut, statIn, hostReadStrobe;
	logic hostWrite_b, holdAck, hostReady, hostIrq_b, localBusRequest_b;
	logic localCpuReset_b, localCpuIrq_b, windowMatch_b, serialCtrlReset_b;
	logic requestToSendChanA, requestToSendChanB;
	logic localHalt_b, clrSeen;
	int mismatches = 0, n_compared = 0, cycles = 0;

	sbha_host_access sbha_host_access_inst (.clock, .rst_b,
		.windowSwitch(8'h5a), .boardSwitch(4'h9), .holdLong(1'b0),
		.mem256k(1'b1), .hostAddr, .hostDataOut, .hostDataIn, .statMemRead,
		.statWriteOut_b, .statOut, .statIn, .hostReadStrobe, .hostWrite_b,
		.holdAck, .hostReady, .hostIrq_b, .localBusRequest_b,
		.localBusGrant_b, .localHalt_b, .localCpuReset_b,
		.localCpuIrq_b, .serialCtrlIrq_b, .memRequest_b, .ioRequest_b,
		.intRead_b, .intWrite_b, .internalAddrLow, .windowMatch_b, .dramPage,
		.serialCtrlReset_b, .serialRdData, .clearToSendChanA,
		.clearToSendChanB(1'b1), .requestToSendChanA, .requestToSendChanB,
		.outputBitsReg, .inputBits);
	sbha_host_model sbha_host_model_inst (.clock, .hostAddr, .hostDataOut,
		.statMemRead, .statWriteOut_b, .statOut, .statIn, .hostReadStrobe,
		.hostWrite_b, .holdAck, .hostReady, .hostDataIn);

	// clock, local cpu grant one cycle after request, strobe capture
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		localBusGrant_b <= localBusRequest_b;
		if (clrSeen)
			seenMatch <= 8'hff;
		if (!memRequest_b || !ioRequest_b) begin
			seenPage <= dramPage;
			seenAddr <= internalAddrLow;
			seenMatch <= {7'h0, windowMatch_b};
		end
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic check(input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic io(input bit wr, input logic [15:0] a, input logic [7:0] d);
		sbha_host_model_inst.run(1, wr, 0, {8'h0, a}, d, q);
	endtask
	// clear the window capture one clock ahead of the cycle
	task automatic mem(input bit dma, input logic [7:0] bank);
		clrSeen <= 1;
		@(posedge clock);
		clrSeen <= 0;
		sbha_host_model_inst.run(0, 0, dma, {bank, 16'h1234}, 8'h0, q);
	endtask
	// reset state of latch and output bits
	task automatic t_reset;
		check({localCpuReset_b, serialCtrlReset_b, hostIrq_b}, 0);
		check({memRequest_b, ioRequest_b, intWrite_b}, 8'h07);
		check(outputBitsReg, 8'h00);
	endtask
	// only the matching board keeps its selection
	task automatic t_select;
		io(1, 16'hfc40, 8'h63);
		io(1, 16'hfc41, 8'h08);
		check(localCpuReset_b, 0);
		io(1, 16'hfc40, 8'hf9);
		io(1, 16'hfc41, 8'h0a);
		check({localCpuReset_b, serialCtrlReset_b}, 3);
	endtask
	// serial ports, output and input bits
	task automatic t_serial;
		io(1, 16'hfc3d, 8'hb6);
		check(outputBitsReg, 8'hb6);
		check(seenAddr, 4'hd);
		check({hostIrq_b, localCpuIrq_b, requestToSendChanB,
			requestToSendChanA}, 8'h06);
		serialCtrlIrq_b <= 0;
		clearToSendChanA <= 0;
		localHalt_b <= 0;
		io(0, 16'hfc35, 8'h0);
		check(q, 8'h3c);
		check(seenAddr, 4'h5);
		check(localCpuIrq_b, 0);
		check({inputBits[6], inputBits[1:0]}, 8'h02);
		// input bits read back: halted, host page 2, chan a not ready
		io(0, 16'hfc3d, 8'h0);
		check(q, 8'h22);
	endtask
	// host, dma and local page choice and window match
	task automatic t_memory;
		mem(0, 8'h5a);
		check(seenMatch, 0);
		check(seenPage, 2);
		// let the hold-off run out and the grant come back
		repeat (4) @(posedge clock);
		check(dramPage, 3);
		io(1, 16'hfc41, 8'h0e);
		io(1, 16'hfc40, 8'h01);
		mem(1, 8'h5a);
		check(seenPage, 1);
		mem(0, 8'h5a);
		check(seenMatch, 8'hff);
		io(1, 16'hfc40, 8'h09);
		io(1, 16'hfc41, 8'h0a);
		mem(1, 8'h5a);
		check(seenMatch, 8'hff);
	endtask

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		rst_b = 0;
		localHalt_b = 1;
		clrSeen = 0;
		serialCtrlIrq_b = 1;
		clearToSendChanA = 1;
		serialRdData = 8'h3c;
		repeat (12) @(posedge clock);
		rst_b <= 1;
		repeat (4) @(posedge clock);
		t_reset();
		t_select();
		t_serial();
		t_memory();
		print_verdict();
	end
endmodule // sbha_host_access_tb_top
